// >>> common/tcoc_pkg.sv
// constants and types for the timer compare-output control block
package tcoc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_MODE_HI = 8'h04;
  localparam logic [7:0] ADR_PIN_EN = 8'h08;
  localparam logic [7:0] ADR_TOP_CAP = 8'h0c;
  localparam logic [7:0] ADR_CMP_A = 8'h10;
  localparam logic [7:0] ADR_CMP_B = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  // ---------------------------------------------------------------
  // field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_ACT_A_LSB = 6;
  localparam int CTRL_ACT_B_LSB = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] MODE_HI_RST = 2'h0;
  localparam logic [1:0] PIN_EN_RST = 2'h0;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] TOP_RST = 16'hffff;
  localparam int NUM_CH = 2;
  // ---------------------------------------------------------------
  // output-action codes
  // ---------------------------------------------------------------
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // ---------------------------------------------------------------
  // waveform modes and fixed tops
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'ha;
  localparam logic [3:0] MODE_PC_CMP = 4'hb;
  localparam logic [3:0] MODE_CTC_CAP = 4'hc;
  localparam logic [3:0] MODE_RSVD = 4'hd;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMP = 4'hf;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  // ---------------------------------------------------------------
  // waveform families
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    WAVE_NONPWM = 4'b0001,
    WAVE_FAST = 4'b0010,
    WAVE_DUAL = 4'b0100,
    WAVE_RSVD = 4'b1000
  } tcoc_wave_t;
endpackage : tcoc_pkg

// >>> src/tcoc_channel.sv
// one compare-output waveform channel
`timescale 1ns/1ns
module tcoc_channel #(
  parameter bit IS_A = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] act,
  input wire tcoc_pkg::tcoc_wave_t wave,
  input wire logic top_bit,
  input wire logic match,
  input wire logic at_top,
  input wire logic cnt_up,
  input wire logic cmp_is_top,
  output logic oc_q,
  output logic conn
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic oc_d;
  wire code_tog = (act == tcoc_pkg::ACT_TOGGLE);
  wire tog_ok = IS_A && top_bit;
  wire is_fast = (wave == tcoc_pkg::WAVE_FAST);
  wire is_dual = (wave == tcoc_pkg::WAVE_DUAL);
  // channel b toggle in pwm is reserved, so it stays off the pin
  assign conn = (act != tcoc_pkg::ACT_OFF) && (wave != tcoc_pkg::WAVE_RSVD)
    && !((is_fast || is_dual) && code_tog && !tog_ok); // [RULE5] [RULE11]
  // a match sitting on top would fight the top action
  wire eff_match = match && !(is_fast && act[1] && cmp_is_top); // [RULE8]
  // ---------------------------------------------------------------
  // next output value
  // ---------------------------------------------------------------
  always_comb
  begin
    oc_d = oc_q;
    case (wave)
      tcoc_pkg::WAVE_NONPWM:
      begin
        if (match && code_tog)
          oc_d = ~oc_q; // [RULE4]
        else if (match && act[1])
          oc_d = act[0]; // [RULE4]
      end
      tcoc_pkg::WAVE_FAST:
      begin
        if (code_tog && tog_ok && match)
          oc_d = ~oc_q; // [RULE5]
        else if (act[1] && at_top)
          oc_d = ~act[0]; // [RULE6] [RULE7]
        else if (act[1] && eff_match)
          oc_d = act[0]; // [RULE6] [RULE7]
      end
      tcoc_pkg::WAVE_DUAL:
      begin
        if (code_tog && tog_ok && match)
          oc_d = ~oc_q; // [RULE11]
        else if (act[1] && match)
          oc_d = act[0] ^ ~cnt_up; // [RULE9] [RULE10]
      end
      default:
        oc_d = oc_q;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      oc_q <= 1'b0;
    else if (ce)
      oc_q <= oc_d;
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_nonpwm_hit;
    ce && wave == tcoc_pkg::WAVE_NONPWM && match;
  endsequence
  sequence s_fast_top;
    ce && is_fast && at_top && act[1];
  endsequence
  sequence s_dual_hit;
    ce && is_dual && match && act[1];
  endsequence

  property p_nonpwm_act;
    @(posedge clk) disable iff (srst)
    s_nonpwm_hit |=> (oc_q == ($past(act) == tcoc_pkg::ACT_TOGGLE ? !$past(oc_q)
      : ($past(act) == tcoc_pkg::ACT_OFF ? $past(oc_q) : $past(act[0]))));
  endproperty
  a_nonpwm_act: assert property (p_nonpwm_act) else $error("non-pwm action wrong"); // [RULE4]

  property p_fast_top;
    @(posedge clk) disable iff (srst)
    s_fast_top |=> oc_q == !$past(act[0]);
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast pwm top action wrong"); // [RULE6]

  property p_fast_match;
    @(posedge clk) disable iff (srst)
    ce && is_fast && act[1] && match && !at_top && !cmp_is_top |=> oc_q == $past(act[0]);
  endproperty
  a_fast_match: assert property (p_fast_match) else $error("fast pwm match wrong"); // [RULE7]

  property p_fast_ignore;
    @(posedge clk) disable iff (srst)
    ce && is_fast && act[1] && cmp_is_top && match && !at_top |=> $stable(oc_q);
  endproperty
  a_fast_ignore: assert property (p_fast_ignore) else $error("match at top not ignored"); // [RULE8]

  property p_dual_clear;
    @(posedge clk) disable iff (srst)
    s_dual_hit ##0 (act == tcoc_pkg::ACT_CLEAR) |=> oc_q == !$past(cnt_up);
  endproperty
  a_dual_clear: assert property (p_dual_clear) else $error("dual-slope clear wrong"); // [RULE9]

  property p_dual_set;
    @(posedge clk) disable iff (srst)
    s_dual_hit ##0 (act == tcoc_pkg::ACT_SET) |=> oc_q == $past(cnt_up);
  endproperty
  a_dual_set: assert property (p_dual_set) else $error("dual-slope set wrong"); // [RULE10]

  property p_pwm_tog_off;
    @(posedge clk) disable iff (srst)
    (is_fast || is_dual) && code_tog && (!top_bit || !IS_A) |-> !conn;
  endproperty
  a_pwm_tog_off: assert property (p_pwm_tog_off) else $error("reserved toggle drives"); // [RULE11]
endmodule : tcoc_channel

// >>> src/tcoc_top.sv
// compare-output control with wishbone register slave and pin muxing
//
// Summary of operation
// RULE1 - nonzero output-action field hands the pin over to the compare output
// RULE2 - compare output drives pin only with direction bit and pin enable set
// RULE3 - pin enable clear keeps normal port use whatever the action field says
// RULE4 - non-pwm codes: off, toggle, clear, set on compare match
// RULE5 - fast pwm toggle code: off unless mode top bit; then only a toggles
// RULE6 - fast pwm code 10 clears on match, sets at top
// RULE7 - fast pwm code 11 sets on match, clears at top
// RULE8 - fast pwm compare equal to top: match ignored, only top action
// RULE9 - dual-slope code 10 clears counting up, sets counting down
// RULE10 - dual-slope code 11 sets counting up, clears counting down
// RULE11 - dual-slope toggle code: off unless mode top bit; then only a toggles
// RULE12 - control bits 7:6 action a, 5:4 action b, read-write, reset zero
// RULE13 - control bits 3:2 reserved, read as zero
// RULE14 - control bits 1:0 low mode bits, joined with two high mode bits
// RULE15 - modes cover plain count, clear on match and three pwm families
// RULE16 - four-bit mode decodes to family and top source per table
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module tcoc_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] cnt_value,
  input wire logic cnt_up,
  input wire logic cnt_tick,
  input wire logic [1:0] port_dout,
  input wire logic [1:0] port_ddr,
  output logic [15:0] top_value,
  output logic [3:0] waveform_mode,
  output logic [1:0] pin_o,
  output logic [1:0] pin_oe_n
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [1:0] mode_hi_q;
  logic [1:0] pin_en_q;
  logic [15:0] top_cap_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] top_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [1:0] pin_o_q;
  logic [1:0] pin_oe_n_q;
  logic [1:0] oc;
  logic [1:0] conn;
  logic [1:0] act [tcoc_pkg::NUM_CH];
  logic [15:0] cmp [tcoc_pkg::NUM_CH];

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i;
  wire rd = req && !wb_we_i;
  wire hit_ctrl = (wb_adr_i == tcoc_pkg::ADR_CTRL);
  wire hit_mode_hi = (wb_adr_i == tcoc_pkg::ADR_MODE_HI);
  wire hit_pin_en = (wb_adr_i == tcoc_pkg::ADR_PIN_EN);
  wire hit_top_cap = (wb_adr_i == tcoc_pkg::ADR_TOP_CAP);
  wire hit_cmp_a = (wb_adr_i == tcoc_pkg::ADR_CMP_A);
  wire hit_cmp_b = (wb_adr_i == tcoc_pkg::ADR_CMP_B);
  wire hit_status = (wb_adr_i == tcoc_pkg::ADR_STATUS);
  wire wr_lo = wr && wb_sel_i[0];
  wire wr_16 = wr && (wb_sel_i[1:0] != 2'h0);
  wire [31:0] status_word = {28'h0000000, conn, oc};
  // unmapped offsets answer with zero and ignore writes
  wire [31:0] rd_d =
    hit_ctrl ? {24'h000000, ctrl_q} :
    hit_mode_hi ? {30'h0, mode_hi_q} :
    hit_pin_en ? {30'h0, pin_en_q} :
    hit_top_cap ? {16'h0000, top_cap_q} :
    hit_cmp_a ? {16'h0000, cmp_a_q} :
    hit_cmp_b ? {16'h0000, cmp_b_q} :
    hit_status ? status_word :
    32'h00000000;
  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // the slave is frozen with the rest: keep ce high across an access
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else if (ce)
    begin
      ack_q <= req;
      if (rd)
        rdat_q <= rd_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_q <= tcoc_pkg::CTRL_RST;
      mode_hi_q <= tcoc_pkg::MODE_HI_RST;
      pin_en_q <= tcoc_pkg::PIN_EN_RST;
    end
    else if (ce && wr_lo)
    begin
      if (hit_ctrl)
        ctrl_q <= wb_dat_i[7:0] & tcoc_pkg::CTRL_WMASK; // [RULE12] [RULE13]
      if (hit_mode_hi)
        mode_hi_q <= wb_dat_i[1:0]; // [RULE14]
      if (hit_pin_en)
        pin_en_q <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      top_cap_q <= tcoc_pkg::CMP_RST;
      cmp_a_q <= tcoc_pkg::CMP_RST;
      cmp_b_q <= tcoc_pkg::CMP_RST;
    end
    else if (ce && wr_16)
    begin
      if (hit_top_cap)
        top_cap_q <= merge16(top_cap_q, wb_dat_i, wb_sel_i);
      if (hit_cmp_a)
        cmp_a_q <= merge16(cmp_a_q, wb_dat_i, wb_sel_i);
      if (hit_cmp_b)
        cmp_b_q <= merge16(cmp_b_q, wb_dat_i, wb_sel_i);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire [3:0] mode = {mode_hi_q, ctrl_q[tcoc_pkg::CTRL_MODE_LSB +: 2]}; // [RULE14]
  wire is_nonpwm = (mode == tcoc_pkg::MODE_NORMAL) || (mode == tcoc_pkg::MODE_CTC_CMP)
    || (mode == tcoc_pkg::MODE_CTC_CAP);
  wire is_fast = (mode == tcoc_pkg::MODE_FAST8) || (mode == tcoc_pkg::MODE_FAST9)
    || (mode == tcoc_pkg::MODE_FAST10) || (mode == tcoc_pkg::MODE_FAST_CAP)
    || (mode == tcoc_pkg::MODE_FAST_CMP);
  wire is_rsvd = (mode == tcoc_pkg::MODE_RSVD);
  // everything left is phase correct or phase and frequency correct
  wire tcoc_pkg::tcoc_wave_t wave =
    is_nonpwm ? tcoc_pkg::WAVE_NONPWM :
    is_fast ? tcoc_pkg::WAVE_FAST :
    is_rsvd ? tcoc_pkg::WAVE_RSVD :
    tcoc_pkg::WAVE_DUAL; // [RULE15] [RULE16]
  wire top_from_cmp = (mode == tcoc_pkg::MODE_CTC_CMP) || (mode == tcoc_pkg::MODE_PFC_CMP)
    || (mode == tcoc_pkg::MODE_PC_CMP) || (mode == tcoc_pkg::MODE_FAST_CMP);
  wire top_from_cap = (mode == tcoc_pkg::MODE_CTC_CAP) || (mode == tcoc_pkg::MODE_PFC_CAP)
    || (mode == tcoc_pkg::MODE_PC_CAP) || (mode == tcoc_pkg::MODE_FAST_CAP);
  wire top_8 = (mode == tcoc_pkg::MODE_PC8) || (mode == tcoc_pkg::MODE_FAST8);
  wire top_9 = (mode == tcoc_pkg::MODE_PC9) || (mode == tcoc_pkg::MODE_FAST9);
  wire top_10 = (mode == tcoc_pkg::MODE_PC10) || (mode == tcoc_pkg::MODE_FAST10);
  wire [15:0] top_d =
    top_from_cmp ? cmp_a_q :
    top_from_cap ? top_cap_q :
    top_8 ? tcoc_pkg::TOP_8 :
    top_9 ? tcoc_pkg::TOP_9 :
    top_10 ? tcoc_pkg::TOP_10 :
    tcoc_pkg::TOP_MAX; // [RULE16]

  always_ff @(posedge clk)
  begin
    if (srst)
      top_q <= tcoc_pkg::TOP_RST;
    else if (ce)
      top_q <= top_d;
  end

  assign top_value = top_q;
  assign waveform_mode = mode;
  // ---------------------------------------------------------------
  // channels and pins
  // ---------------------------------------------------------------
  // matches use the registered top, one cycle behind a mode change
  wire at_top = cnt_tick && (cnt_value == top_q);
  assign act[0] = ctrl_q[tcoc_pkg::CTRL_ACT_A_LSB +: 2]; // [RULE12]
  assign act[1] = ctrl_q[tcoc_pkg::CTRL_ACT_B_LSB +: 2]; // [RULE12]
  assign cmp[0] = cmp_a_q;
  assign cmp[1] = cmp_b_q;

  genvar gi;
  generate
    for (gi = 0; gi < tcoc_pkg::NUM_CH; gi++)
    begin : g_ch
      wire match = cnt_tick && (cnt_value == cmp[gi]);
      wire take = conn[gi] && pin_en_q[gi]; // [RULE1] [RULE3]

      tcoc_channel #(
        .IS_A(gi == 0)
      ) u_ch (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .act(act[gi]),
        .wave(wave),
        .top_bit(mode_hi_q[1]),
        .match(match),
        .at_top(at_top),
        .cnt_up(cnt_up),
        .cmp_is_top(cmp[gi] == top_q),
        .oc_q(oc[gi]),
        .conn(conn[gi])
      );

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          pin_o_q[gi] <= 1'b0;
          pin_oe_n_q[gi] <= 1'b1;
        end
        else if (ce)
        begin
          pin_o_q[gi] <= take ? oc[gi] : port_dout[gi]; // [RULE1] [RULE3]
          pin_oe_n_q[gi] <= !port_ddr[gi]; // [RULE2]
        end
      end

      property p_take_pin;
        @(posedge clk) disable iff (srst)
        ce && take && port_ddr[gi] |=> !pin_oe_n_q[gi] && pin_o_q[gi] == $past(oc[gi]);
      endproperty
      a_take_pin: assert property (p_take_pin) else $error("compare output not on pin"); // [RULE1]

      property p_no_ddr;
        @(posedge clk) disable iff (srst)
        ce && !port_ddr[gi] |=> pin_oe_n_q[gi];
      endproperty
      a_no_ddr: assert property (p_no_ddr) else $error("pin driven without direction"); // [RULE2]

      property p_pin_off;
        @(posedge clk) disable iff (srst)
        ce && (!pin_en_q[gi] || act[gi] == tcoc_pkg::ACT_OFF)
          |=> pin_o_q[gi] == $past(port_dout[gi]);
      endproperty
      a_pin_off: assert property (p_pin_off) else $error("port function lost"); // [RULE3]
    end
  endgenerate

  assign pin_o = pin_o_q;
  assign pin_oe_n = pin_oe_n_q;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_ctrl_wr;
    ce && wr_lo && hit_ctrl;
  endsequence
  sequence s_ctrl_rd;
    ce && rd && hit_ctrl;
  endsequence

  property p_ctrl_wr;
    @(posedge clk) disable iff (srst)
    s_ctrl_wr |=> ctrl_q == ($past(wb_dat_i[7:0]) & tcoc_pkg::CTRL_WMASK) && wb_ack_o;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // [RULE12]

  property p_ctrl_rd;
    @(posedge clk) disable iff (srst)
    s_ctrl_rd |=> wb_ack_o && wb_dat_o[3:2] == 2'h0 && wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("reserved control bits read nonzero"); // [RULE13]

  property p_mode_join;
    @(posedge clk) disable iff (srst)
    ce && wr_lo && hit_mode_hi
      |=> waveform_mode == {$past(wb_dat_i[1:0]), $past(ctrl_q[1:0])};
  endproperty
  a_mode_join: assert property (p_mode_join) else $error("mode bits not joined"); // [RULE14]

  property p_fam;
    @(posedge clk) disable iff (srst)
    (mode == tcoc_pkg::MODE_CTC_CAP |-> wave == tcoc_pkg::WAVE_NONPWM)
      and (mode == tcoc_pkg::MODE_FAST_CAP |-> wave == tcoc_pkg::WAVE_FAST)
      and (mode == tcoc_pkg::MODE_PFC_CMP |-> wave == tcoc_pkg::WAVE_DUAL);
  endproperty
  a_fam: assert property (p_fam) else $error("mode family wrong"); // [RULE15]

  property p_top_fixed;
    @(posedge clk) disable iff (srst)
    ce && mode == tcoc_pkg::MODE_PC9 |=> top_value == 16'h01ff;
  endproperty
  a_top_fixed: assert property (p_top_fixed) else $error("fixed top wrong"); // [RULE16]

  property p_top_cmp;
    @(posedge clk) disable iff (srst)
    ce && mode == tcoc_pkg::MODE_CTC_CMP |=> top_value == $past(cmp_a_q);
  endproperty
  a_top_cmp: assert property (p_top_cmp) else $error("compare top wrong"); // [RULE16]

  property p_ack_one;
    @(posedge clk) disable iff (srst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle"); // [RULE12]
endmodule : tcoc_top

// >>> test/test_tcoc_top.sv
// self-checking bench for the timer compare-output control block
`timescale 1ns/1ns
module test_tcoc_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] cnt_value = 16'h0000;
  logic cnt_up = 1'b1;
  logic cnt_tick = 1'b0;
  logic [1:0] port_dout = 2'h0;
  logic [1:0] port_ddr = 2'h0;
  logic [15:0] top_value;
  logic [3:0] waveform_mode;
  logic [1:0] pin_o;
  logic [1:0] pin_oe_n;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [15:0] cmp_v;
  logic [15:0] cap_v;
  logic [1:0] dv;
  logic [7:0] rv;
  logic [1:0] codes[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic [3:0] nmodes[4] = '{4'h0, 4'h4, 4'hc, 4'h0};
  logic ocs[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #25 clk = ~clk;
  tcoc_top tcoc_top_inst (.clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cnt_value(cnt_value),
    .cnt_up(cnt_up), .cnt_tick(cnt_tick), .port_dout(port_dout), .port_ddr(port_ddr),
    .top_value(top_value), .waveform_mode(waveform_mode), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n));
  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // read results are judged here, oldest note first
  always @(posedge clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
    begin
      chk("wb_dat_o", exp_q[0] & msk_q[0], wb_dat_o & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
      miscompares++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic setm(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
    wr(tcoc_pkg::ADR_CTRL, {24'h0, aa, ab, 2'h0, m[1:0]});
    wr(tcoc_pkg::ADR_MODE_HI, {30'h0, m[3:2]});
  endtask : setm
  // one counter tick, then pins and status {conn_b,conn_a,oc_b,oc_a}
  task automatic ev(input logic [15:0] v, input logic up, input logic [3:0] st,
    input logic [3:0] m, input logic [1:0] pe);
    @(posedge clk);
    cnt_value <= v;
    cnt_up <= up;
    cnt_tick <= 1'b1;
    @(posedge clk);
    cnt_tick <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("pin_o", 32'(pe), 32'(pin_o));
    rd(tcoc_pkg::ADR_STATUS, 32'(st), 32'(m));
  endtask : ev
  function automatic logic [15:0] exp_top(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: return tcoc_pkg::TOP_8;
      4'h2, 4'h6: return tcoc_pkg::TOP_9;
      4'h3, 4'h7: return tcoc_pkg::TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: return cmp_v;
      4'h8, 4'ha, 4'hc, 4'he: return cap_v;
      default: return tcoc_pkg::TOP_MAX;
    endcase
  endfunction : exp_top
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(82));
    dv = 2'($urandom);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    port_dout <= dv;
    @(negedge clk);
    chk("top_value", 32'h0000ffff, 32'(top_value));
    chk("pin_oe_n", 32'h3, 32'(pin_oe_n));
    rd(tcoc_pkg::ADR_CTRL, 32'h0, 32'hffffffff);
    rd(tcoc_pkg::ADR_PIN_EN, 32'h0, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    wr(tcoc_pkg::ADR_CTRL, 32'hffffffff);
    rd(tcoc_pkg::ADR_CTRL, 32'hf3, 32'hffffffff);
    rv = 8'($urandom);
    wr(tcoc_pkg::ADR_CTRL, 32'(rv));
    rd(tcoc_pkg::ADR_CTRL, 32'(rv & 8'hf3), 32'hffffffff);
    $display("test registers done");
    cmp_v = 16'($urandom);
    cap_v = 16'($urandom);
    wr(tcoc_pkg::ADR_CMP_A, 32'(cmp_v));
    wr(tcoc_pkg::ADR_TOP_CAP, 32'(cap_v));
    for (int m = 0; m < 16; m++)
    begin
      setm(4'(m), 2'h0, 2'h0);
      @(negedge clk);
      chk("waveform_mode", 32'(m), 32'(waveform_mode));
      chk("top_value", 32'(exp_top(4'(m))), 32'(top_value));
    end
    $display("test modes done");
    wr(tcoc_pkg::ADR_PIN_EN, 32'h3);
    wr(tcoc_pkg::ADR_CMP_A, 32'h40);
    wr(tcoc_pkg::ADR_CMP_B, 32'h40);
    port_ddr <= 2'h3;
    for (int i = 0; i < 4; i++)
    begin
      setm(nmodes[i], codes[i], codes[i]);
      ev(16'h40, 1'b1, {2'h3, ocs[i], ocs[i]}, 4'hf, {ocs[i], ocs[i]});
    end
    setm(4'h0, 2'h0, 2'h0);
    ev(16'h40, 1'b1, 4'h0, 4'hc, dv);
    wr(tcoc_pkg::ADR_PIN_EN, 32'h0);
    setm(4'h0, 2'h3, 2'h3);
    ev(16'h40, 1'b1, 4'h3, 4'h3, dv);
    port_ddr <= 2'h1;
    repeat (2) @(negedge clk);
    chk("pin_oe_n", 32'h2, 32'(pin_oe_n));
    @(posedge clk);
    port_ddr <= 2'h3;
    $display("test non-pwm done");
    wr(tcoc_pkg::ADR_PIN_EN, 32'h3);
    wr(tcoc_pkg::ADR_TOP_CAP, 32'h100);
    setm(4'he, 2'h2, 2'h3);
    ev(16'h100, 1'b1, 4'hd, 4'hf, 2'h1);
    ev(16'h40, 1'b1, 4'he, 4'hf, 2'h2);
    setm(4'he, 2'h3, 2'h2);
    ev(16'h40, 1'b1, 4'hd, 4'hf, 2'h1);
    wr(tcoc_pkg::ADR_CMP_A, 32'h100);
    ev(16'h100, 1'b1, 4'he, 4'hf, 2'h2);
    wr(tcoc_pkg::ADR_CMP_A, 32'h40);
    setm(4'h5, 2'h1, 2'h1);
    ev(16'h30, 1'b1, 4'h0, 4'hc, dv);
    setm(4'he, 2'h1, 2'h1);
    ev(16'h40, 1'b1, 4'h5, 4'hd, {dv[1], 1'b1});
    $display("test fast pwm done");
    setm(4'h8, 2'h2, 2'h3);
    ev(16'h40, 1'b1, 4'he, 4'hf, 2'h2);
    ev(16'h40, 1'b0, 4'hd, 4'hf, 2'h1);
    setm(4'ha, 2'h3, 2'h2);
    ev(16'h40, 1'b1, 4'hd, 4'hf, 2'h1);
    ev(16'h40, 1'b0, 4'he, 4'hf, 2'h2);
    setm(4'h1, 2'h1, 2'h1);
    ev(16'h30, 1'b1, 4'h0, 4'hc, dv);
    setm(4'ha, 2'h1, 2'h1);
    ev(16'h40, 1'b1, 4'h5, 4'hd, {dv[1], 1'b1});
    $display("test dual-slope done");
    // a tick while ce is low must leave the toggling output alone
    @(posedge clk);
    ce <= 1'b0;
    cnt_tick <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    cnt_tick <= 1'b0;
    rd(tcoc_pkg::ADR_STATUS, 32'h5, 32'hd);
    $display("test clock enable done");
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : test_tcoc_top
